// ### logic/uprd_consts.vh
// constants shared by the udp port resource dispatcher and its buffer
// assumes a 100 MHz system clock and a udp layer that strips ip headers
`ifndef UPRD_CONSTS_VH
`define UPRD_CONSTS_VH

// ----------------------------------------------------------------------
// resources and port map
// ----------------------------------------------------------------------
`define UPRD_RES_N        5
`define UPRD_BASE_PORT    16'h2710
`define UPRD_RES_N16      16'h0005
`define UPRD_DEFAULT_IP   32'h0a0a0a01

// ----------------------------------------------------------------------
// sizes, bytes
// ----------------------------------------------------------------------
`define UPRD_UDP_HDR      16'h0008
`define UPRD_IP_HDR       16'h0014
`define UPRD_MAX_FRAME    16'h05dc
`define UPRD_MAX_PAYLOAD  (`UPRD_MAX_FRAME - `UPRD_IP_HDR - `UPRD_UDP_HDR)
`define UPRD_MIN_UDP_LEN  16'h0009

// ----------------------------------------------------------------------
// per resource storage
// ----------------------------------------------------------------------
`define UPRD_MEM_AW       11
`define UPRD_MEM_BYTES    12'h800
`define UPRD_DESC_AW      2
`define UPRD_DESC_DEPTH   3'h4

// ----------------------------------------------------------------------
// watchdog timing
// ----------------------------------------------------------------------
`define UPRD_CLK_MHZ      100
`define UPRD_TIMEOUT_MS   1000
`define UPRD_TIMEOUT_CYC  (`UPRD_TIMEOUT_MS * 1000 * `UPRD_CLK_MHZ)

// ----------------------------------------------------------------------
// response buffer word layout
// ----------------------------------------------------------------------
`define UPRD_BW           92
`define UPRD_B_DATA       7:0
`define UPRD_B_LAST       8
`define UPRD_B_RID        11:9
`define UPRD_B_IP         43:12
`define UPRD_B_DPORT      59:44
`define UPRD_B_SPORT      75:60
`define UPRD_B_ULEN       91:76

`endif

// ### logic/uprd_skid2.v
// two entry valid/ready buffer on the response path
// assumes one clock and an active low synchronous reset
`include "uprd_consts.vh"

module uprd_skid2 #(
	parameter W = `UPRD_BW
) (
	input  wire         clock_in,
	input  wire         rst_b_in,
	input  wire         in_valid_in,
	output reg          in_ready_out,
	output wire         room_next_out,
	input  wire [W-1:0] in_data_in,
	output reg          out_valid_out,
	input  wire         out_ready_in,
	output wire [W-1:0] out_data_out
);
	// ------------------------------------------------------------------
	// storage
	// ------------------------------------------------------------------
	reg  [W-1:0] head;        // entry seen at the output
	reg  [W-1:0] tail;        // second entry
	reg  [1:0]   cnt;         // words held
	reg  [1:0]   next_cnt;    // words held after this edge
	wire         push;        // word enters
	wire         pop;         // word leaves

	assign push          = in_valid_in & in_ready_out;
	assign pop           = out_valid_out & out_ready_in;
	assign out_data_out  = head;
	assign room_next_out = (next_cnt != 2'h2);

	// occupancy after this cycle
	always @* begin
		next_cnt = cnt;
		if (push & ~pop)
			next_cnt = cnt + 2'h1;
		else if (pop & ~push)
			next_cnt = cnt - 2'h1;
	end

	// entries move toward the head; flags follow next_cnt
	always @(posedge clock_in) begin
		if (!rst_b_in) begin
			head          <= {W{1'b0}};
			tail          <= {W{1'b0}};
			cnt           <= 2'h0;
			in_ready_out  <= 1'b0;
			out_valid_out <= 1'b0;
		end else begin
			if (push & ~pop) begin
				if (cnt == 2'h0)
					head <= in_data_in;
				else
					tail <= in_data_in;
			end else if (pop & ~push) begin
				head <= tail;
			end else if (pop & push) begin
				// one held: new word becomes head; two held: shift
				if (cnt == 2'h1) begin
					head <= in_data_in;
				end else begin
					head <= tail;
					tail <= in_data_in;
				end
			end
			cnt           <= next_cnt;
			in_ready_out  <= (next_cnt != 2'h2);
			out_valid_out <= (next_cnt != 2'h0);
		end
	end
endmodule // uprd_skid2

// ### logic/uprd_dispatch.v
// udp port resource dispatcher: routes command datagrams to five
// resources, queues them per resource and returns the responses
// assumes the udp layer below presents one datagram per rx burst with
// its header fields held steady for the whole burst, one byte a beat
`include "uprd_consts.vh"

module uprd_dispatch #(
	parameter [31:0] TIMEOUT_CYC = `UPRD_TIMEOUT_CYC
) (
	input  wire        clock_in,
	input  wire        rst_b_in,
	input  wire        ip_load_in,
	input  wire [31:0] ip_value_in,
	input  wire        rx_valid_in,
	output reg         rx_ready_out,
	input  wire [7:0]  rx_data_in,
	input  wire        rx_last_in,
	input  wire [31:0] rx_dst_ip_in,
	input  wire [31:0] rx_src_ip_in,
	input  wire [15:0] rx_src_port_in,
	input  wire [15:0] rx_dst_port_in,
	input  wire [15:0] rx_udp_len_in,
	output wire [4:0]  cmd_valid_out,
	input  wire [4:0]  cmd_ready_in,
	output wire [39:0] cmd_data_out,
	output wire [4:0]  cmd_last_out,
	input  wire [4:0]  rsp_valid_in,
	output reg  [4:0]  rsp_ready_out,
	input  wire [39:0] rsp_data_in,
	input  wire [4:0]  rsp_last_in,
	input  wire [54:0] rsp_len_in,
	output wire        tx_valid_out,
	input  wire        tx_ready_in,
	output wire [7:0]  tx_data_out,
	output wire        tx_last_out,
	output wire [31:0] tx_dst_ip_out,
	output wire [15:0] tx_dst_port_out,
	output wire [15:0] tx_src_port_out,
	output wire [15:0] tx_udp_len_out,
	output wire [4:0]  busy_out,
	output reg         drop_out,
	output reg         self_reset_out,
	output reg  [31:0] ip_addr_out
);
	// ------------------------------------------------------------------
	// thread states, one hot
	// ------------------------------------------------------------------
	localparam [3:0] ST_IDLE = 4'h1;  // no execution
	localparam [3:0] ST_LOAD = 4'h2;  // command bytes to resource
	localparam [3:0] ST_WAIT = 4'h4;  // awaiting response bytes
	localparam [3:0] ST_SEND = 4'h8;  // response queued for transmit

	// ------------------------------------------------------------------
	// reset and watchdog
	// ------------------------------------------------------------------
	reg         wd_fire;      // timeout reached, one cycle
	reg  [31:0] wd_cnt;       // cycles since last accepted command
	wire        rst_n;        // hardware or watchdog reset, active low
	wire [4:0]  commit;       // accepted command per resource

	assign rst_n = rst_b_in & ~wd_fire;

	// watchdog: any accepted command restarts it
	always @(posedge clock_in) begin
		if (!rst_b_in) begin
			wd_cnt         <= 32'h0;
			wd_fire        <= 1'b0;
			self_reset_out <= 1'b0;
		end else begin
			wd_fire        <= 1'b0;
			self_reset_out <= 1'b0;
			if (commit != 5'h0) begin
				wd_cnt <= 32'h0;
			end else if (wd_cnt >= TIMEOUT_CYC - 32'h1) begin
				wd_cnt         <= 32'h0;
				wd_fire        <= 1'b1;
				self_reset_out <= 1'b1;
			end else begin
				wd_cnt <= wd_cnt + 32'h1;
			end
		end
	end

	// own address: default after any reset, loadable afterwards
	always @(posedge clock_in) begin
		if (!rst_n)
			ip_addr_out <= `UPRD_DEFAULT_IP;
		else if (ip_load_in)
			ip_addr_out <= ip_value_in;
	end

	// ------------------------------------------------------------------
	// receive classification
	// ------------------------------------------------------------------
	reg         in_pkt;       // inside a datagram burst
	reg         in_keep;      // current burst is stored
	reg  [2:0]  in_sel;       // resource of current burst
	reg  [10:0] in_len;       // payload bytes promised by header
	reg  [10:0] in_cnt;       // payload bytes stored so far
	wire [15:0] port_off;     // destination port minus gateway port
	wire [15:0] pay_len16;    // payload length from udp length
	wire        port_ok;      // one of the five ports
	wire        len_ok;       // nonempty and within frame limit
	wire        ip_ok;        // addressed to us
	wire [7:0]  space_ok;     // room for the datagram, per resource
	wire        beat;         // rx byte taken
	wire        first;        // first byte of a burst
	wire        cls_keep;     // first byte decides to store
	wire        keep_now;     // store decision for this beat
	wire [2:0]  sel_now;      // resource for this beat
	wire [10:0] len_now;      // promised length for this beat
	wire [10:0] cnt_now;      // bytes stored before this beat
	wire        wr_now;       // this beat writes a byte
	wire        good_end;     // last beat, count equals header length

	assign port_off  = rx_dst_port_in - `UPRD_BASE_PORT;
	assign port_ok   = (rx_dst_port_in >= `UPRD_BASE_PORT) &&
	                   (port_off < `UPRD_RES_N16);
	assign pay_len16 = rx_udp_len_in - `UPRD_UDP_HDR;
	assign len_ok    = (rx_udp_len_in >= `UPRD_MIN_UDP_LEN) &&
	                   (pay_len16 <= `UPRD_MAX_PAYLOAD);
	assign ip_ok     = (rx_dst_ip_in == ip_addr_out);
	assign beat      = rx_valid_in & rx_ready_out;
	assign first     = beat & ~in_pkt;
	// space checked against the target only, others unaffected
	assign cls_keep  = ip_ok & port_ok & len_ok &
	                   space_ok[port_off[2:0]];
	assign keep_now  = first ? cls_keep : in_keep;
	assign sel_now   = first ? port_off[2:0] : in_sel;
	assign len_now   = first ? pay_len16[10:0] : in_len;
	assign cnt_now   = first ? 11'h0 : in_cnt;
	assign wr_now    = beat & keep_now & (cnt_now < len_now);
	// whole payload, nothing less; bytes past the header length are ignored
	assign good_end  = beat & rx_last_in & keep_now &
	                   ((cnt_now + {10'h0, wr_now}) == len_now);

	// burst tracking; never stalls, drops instead
	always @(posedge clock_in) begin
		if (!rst_n) begin
			rx_ready_out <= 1'b0;
			in_pkt       <= 1'b0;
			in_keep      <= 1'b0;
			in_sel       <= 3'h0;
			in_len       <= 11'h0;
			in_cnt       <= 11'h0;
			drop_out     <= 1'b0;
		end else begin
			rx_ready_out <= 1'b1;
			drop_out     <= 1'b0;
			if (beat) begin
				in_pkt  <= ~rx_last_in;
				in_keep <= keep_now;
				in_sel  <= sel_now;
				in_len  <= len_now;
				in_cnt  <= cnt_now + {10'h0, wr_now};
				// discarded without any answer
				if (rx_last_in & ~good_end)
					drop_out <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// response arbitration into the two entry buffer
	// ------------------------------------------------------------------
	reg         owning;       // a resource holds the response path
	reg  [2:0]  owner;        // which one
	reg         next_owning;  // owning after this edge
	reg  [2:0]  next_owner;   // owner after this edge
	reg         pick_ok;      // a resource asks for the path
	reg  [2:0]  pick;         // lowest asking resource
	reg  [`UPRD_BW-1:0] bin;  // word entering the buffer
	wire [4:0]  asking;       // resource waits with response data
	wire        b_in_ready;   // buffer accepts
	wire        b_room_next;  // buffer has room next cycle
	wire        b_out_valid;  // buffer head valid
	wire [`UPRD_BW-1:0] bout; // buffer head
	wire        hs;           // response byte taken
	wire        hs_last;      // last response byte taken
	wire        tx_done;      // last response byte transmitted
	wire [31:0] cur_ip_v [0:4];   // originator address per resource
	wire [15:0] cur_port_v [0:4]; // originator port per resource
	integer     k;

	assign hs      = owning & rsp_valid_in[owner] & rsp_ready_out[owner] &
	                 b_in_ready;
	assign hs_last = hs & rsp_last_in[owner];
	assign tx_done = b_out_valid & tx_ready_in & bout[`UPRD_B_LAST];

	// lowest waiting resource wins a free path
	always @* begin
		pick_ok = 1'b0;
		pick    = 3'h0;
		for (k = `UPRD_RES_N - 1; k >= 0; k = k - 1) begin
			if (asking[k]) begin
				pick_ok = 1'b1;
				pick    = k[2:0];
			end
		end
	end

	// path held from first to last response byte
	always @* begin
		next_owning = owning;
		next_owner  = owner;
		if (owning & hs_last) begin
			next_owning = 1'b0;
		end else if (~owning & pick_ok) begin
			next_owning = 1'b1;
			next_owner  = pick;
		end
	end

	// buffer word: byte, sender address, our port and udp length
	always @* begin
		bin                = {`UPRD_BW{1'b0}};
		bin[`UPRD_B_DATA]  = rsp_data_in[owner*8 +: 8];
		bin[`UPRD_B_LAST]  = rsp_last_in[owner];
		bin[`UPRD_B_RID]   = owner;
		bin[`UPRD_B_IP]    = cur_ip_v[owner];
		bin[`UPRD_B_DPORT] = cur_port_v[owner];
		bin[`UPRD_B_SPORT] = `UPRD_BASE_PORT + {13'h0, owner};
		// whole response in one datagram, length in header
		bin[`UPRD_B_ULEN]  = {5'h0, rsp_len_in[owner*11 +: 11]} +
		                     `UPRD_UDP_HDR;
	end

	// ready to a resource is registered from next path state
	always @(posedge clock_in) begin
		if (!rst_n) begin
			owning        <= 1'b0;
			owner         <= 3'h0;
			rsp_ready_out <= 5'h0;
		end else begin
			owning <= next_owning;
			owner  <= next_owner;
			for (k = 0; k < `UPRD_RES_N; k = k + 1)
				rsp_ready_out[k] <= next_owning & b_room_next &
				                    (next_owner == k[2:0]);
		end
	end

	uprd_skid2 #(
		.W (`UPRD_BW)
	) u_buf (
		.clock_in      (clock_in),
		.rst_b_in      (rst_n),
		.in_valid_in   (hs),
		.in_ready_out  (b_in_ready),
		.room_next_out (b_room_next),
		.in_data_in    (bin),
		.out_valid_out (b_out_valid),
		.out_ready_in  (tx_ready_in),
		.out_data_out  (bout)
	);

	assign tx_valid_out    = b_out_valid;
	assign tx_data_out     = bout[`UPRD_B_DATA];
	assign tx_last_out     = bout[`UPRD_B_LAST];
	assign tx_dst_ip_out   = bout[`UPRD_B_IP];
	assign tx_dst_port_out = bout[`UPRD_B_DPORT];
	assign tx_src_port_out = bout[`UPRD_B_SPORT];
	assign tx_udp_len_out  = bout[`UPRD_B_ULEN];

	assign space_ok[7:5] = 3'h0;

	// ------------------------------------------------------------------
	// one context per resource
	// ------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < `UPRD_RES_N; g = g + 1) begin : res
			reg  [7:0]  mem [0:`UPRD_MEM_BYTES-1]; // payload ring
			reg  [58:0] dq [0:`UPRD_DESC_DEPTH-1]; // ip, port, length
			reg  [11:0] wp;       // write pointer, tentative
			reg  [11:0] cp;       // write pointer, committed
			reg  [11:0] rp;       // read pointer
			reg  [2:0]  dw;       // descriptor write pointer
			reg  [2:0]  dr;       // descriptor read pointer
			reg  [3:0]  st;       // thread state
			reg  [10:0] left;     // command bytes still to emit
			reg  [31:0] cur_ip;   // originator address
			reg  [15:0] cur_port; // originator port
			reg         cv;       // command byte valid
			reg  [7:0]  cd;       // command byte
			reg         cl;       // command byte is last
			reg         busy;     // execution active
			wire [11:0] free;     // free payload bytes
			wire        hit;      // this beat belongs here
			wire        cmd_hs;   // command byte taken

			assign free     = `UPRD_MEM_BYTES - (cp - rp);
			assign space_ok[g] = ((dw - dr) != `UPRD_DESC_DEPTH) &&
			                     (free >= {1'b0, pay_len16[10:0]});
			assign hit      = beat & keep_now & (sel_now == g);
			assign commit[g] = hit & good_end;
			assign cmd_hs   = cv & cmd_ready_in[g];
			assign asking[g] = (st == ST_WAIT) & rsp_valid_in[g];
			assign cur_ip_v[g]   = cur_ip;
			assign cur_port_v[g] = cur_port;
			assign cmd_valid_out[g]      = cv;
			assign cmd_data_out[g*8 +: 8] = cd;
			assign cmd_last_out[g]       = cl;
			assign busy_out[g]           = busy;

			// payload bytes; no reset needed on the array
			always @(posedge clock_in) begin
				if (hit & wr_now)
					mem[wp[`UPRD_MEM_AW-1:0]] <= rx_data_in;
			end

			// descriptor queue in arrival order
			always @(posedge clock_in) begin
				if (commit[g])
					dq[dw[`UPRD_DESC_AW-1:0]] <= {rx_src_ip_in,
					                             rx_src_port_in, len_now};
			end

			// write side: keep a good datagram, rewind a bad one
			always @(posedge clock_in) begin
				if (!rst_n) begin
					wp <= 12'h0;
					cp <= 12'h0;
					dw <= 3'h0;
				end else if (hit & rx_last_in) begin
					if (good_end) begin
						cp <= wp + {11'h0, wr_now};
						wp <= wp + {11'h0, wr_now};
						dw <= dw + 3'h1;
					end else begin
						wp <= cp;
					end
				end else if (hit & wr_now) begin
					wp <= wp + 12'h1;
				end
			end

			// thread: launch, feed, wait, finish on transmit
			always @(posedge clock_in) begin
				if (!rst_n) begin
					st       <= ST_IDLE;
					dr       <= 3'h0;
					rp       <= 12'h0;
					left     <= 11'h0;
					cur_ip   <= 32'h0;
					cur_port <= 16'h0;
					cv       <= 1'b0;
					cd       <= 8'h0;
					cl       <= 1'b0;
					busy     <= 1'b0;
				end else begin
					case (st)
					ST_IDLE: begin
						// oldest queued command launches the thread
						if (dr != dw) begin
							{cur_ip, cur_port, left} <=
								dq[dr[`UPRD_DESC_AW-1:0]];
							dr   <= dr + 3'h1;
							busy <= 1'b1;
							st   <= ST_LOAD;
						end
					end
					ST_LOAD: begin
						// one registered byte at a time
						if (~cv | cmd_ready_in[g]) begin
							if (left != 11'h0) begin
								cv   <= 1'b1;
								cd   <= mem[rp[`UPRD_MEM_AW-1:0]];
								cl   <= (left == 11'h1);
								rp   <= rp + 12'h1;
								left <= left - 11'h1;
							end else begin
								cv <= 1'b0;
								cl <= 1'b0;
							end
						end
						if (cmd_hs & cl)
							st <= ST_WAIT;
					end
					ST_WAIT: begin
						// response fully in the buffer
						if (hs_last & (owner == g))
							st <= ST_SEND;
					end
					ST_SEND: begin
						// thread ends when the last byte leaves
						if (tx_done & (bout[`UPRD_B_RID] == g)) begin
							st   <= ST_IDLE;
							busy <= 1'b0;
						end
					end
					default: begin
						st <= ST_IDLE;
					end
					endcase
				end
			end
		end
	endgenerate
endmodule // uprd_dispatch

// ### verification/uprd_dispatch_sva.sv
// checker for the dispatcher, watching top level ports only
// assumes one clock, synchronous active low reset, short watchdog
module uprd_dispatch_sva #(
	parameter [31:0] TIMEOUT_CYC = 32'd2000
) (
	input wire        clock_in,
	input wire        rst_b_in,
	input wire        rx_valid_in,
	input wire        rx_ready_out,
	input wire        rx_last_in,
	input wire [31:0] rx_dst_ip_in,
	input wire [15:0] rx_dst_port_in,
	input wire [15:0] rx_udp_len_in,
	input wire        tx_valid_out,
	input wire        tx_ready_in,
	input wire        tx_last_out,
	input wire [7:0]  tx_data_out,
	input wire [15:0] tx_dst_port_out,
	input wire [15:0] tx_src_port_out,
	input wire [4:0]  busy_out,
	input wire        drop_out,
	input wire        self_reset_out,
	input wire [31:0] ip_addr_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);
	// ------------------------------------------------------------
	// sequences and helper logic
	// ------------------------------------------------------------
	// last beat of a datagram taken
	sequence s_last;
		rx_valid_in && rx_ready_out && rx_last_in;
	endsequence
	reg [31:0] quiet; // cycles since reset, beat or watchdog pulse
	always @(posedge clock_in) begin
		if (!rst_b_in || self_reset_out || (rx_valid_in && rx_ready_out))
			quiet <= 32'h0;
		else
			quiet <= quiet + 32'h1;
	end
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_ready_release: assert property ($rose(rst_b_in) |=> rx_ready_out)
		else $error("rx ready missing after reset");
	a_ip_default: assert property (disable iff (1'b0)
		!rst_b_in |=> ip_addr_out == 32'h0a0a0a01)
		else $error("own address not default after reset");
	a_drop_port: assert property (s_last ##0
		(rx_dst_port_in < 16'h2710 || rx_dst_port_in > 16'h2714) |=> drop_out)
		else $error("unsupported port not dropped");
	a_drop_ip: assert property (s_last ##0
		(rx_dst_ip_in != ip_addr_out) |=> drop_out)
		else $error("foreign address not dropped");
	a_drop_short: assert property (s_last ##0
		(rx_udp_len_in < 16'h0009) |=> drop_out)
		else $error("short length not dropped");
	a_busy_end: assert property (|($past(busy_out) & ~busy_out) |->
		$past(tx_valid_out && tx_ready_in && tx_last_out, 1) ||
		$past(tx_valid_out && tx_ready_in && tx_last_out, 2) ||
		self_reset_out || $past(self_reset_out))
		else $error("thread ended without reply");
	a_wdog_clear: assert property (self_reset_out |-> ##[0:1]
		busy_out == 5'h00)
		else $error("watchdog left a thread running");
	a_wdog_bound: assert property (quiet <= TIMEOUT_CYC + 32'd4)
		else $error("watchdog did not fire");
	a_src_port: assert property (tx_valid_out |->
		tx_src_port_out >= 16'h2710 && tx_src_port_out <= 16'h2714)
		else $error("reply source port outside map");
	a_tx_hold: assert property (tx_valid_out && !tx_ready_in |=>
		tx_valid_out && $stable(tx_data_out) && $stable(tx_dst_port_out))
		else $error("reply changed while stalled");
endmodule // uprd_dispatch_sva

bind uprd_dispatch uprd_dispatch_sva #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk_i (.*);

// ### verification/uprd_client_sink.sv
// client model: takes reply datagrams off the tx stream and logs them
// assumes headers held for the whole reply
module uprd_client_sink (
	input  wire        clock_in,
	input  wire        stall_in,
	input  wire        tx_valid_in,
	input  wire [7:0]  tx_data_in,
	input  wire        tx_last_in,
	input  wire [31:0] tx_dst_ip_in,
	input  wire [15:0] tx_dst_port_in,
	input  wire [15:0] tx_src_port_in,
	input  wire [15:0] tx_udp_len_in,
	output reg         tx_ready_out
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [15:0] dport [0:31]; // reply port per reply
	reg [15:0] sport [0:31]; // resource port per reply
	reg [31:0] dip   [0:31]; // reply address per reply
	reg [7:0]  dat   [0:31]; // last byte per reply
	reg [15:0] nbyte;        // bytes of the current reply
	reg        bad_len;      // size disagrees with udp length
	int        n_rsp;        // replies seen
	initial begin
		n_rsp = 0;
		nbyte = 16'h0;
		bad_len = 1'b0;
		tx_ready_out = 1'b0;
	end
	// ready moves off the sampling edge
	always @(negedge clock_in) tx_ready_out <= !stall_in;
	// size each reply by its udp length
	always @(posedge clock_in) begin
		if (tx_valid_in && tx_ready_out) begin
			nbyte = nbyte + 16'h1;
			if (tx_last_in) begin
				if (nbyte + 16'h8 != tx_udp_len_in) bad_len = 1'b1;
				dport[n_rsp] = tx_dst_port_in;
				sport[n_rsp] = tx_src_port_in;
				dip[n_rsp] = tx_dst_ip_in;
				dat[n_rsp] = tx_data_in;
				n_rsp = n_rsp + 1;
				nbyte = 16'h0;
			end
		end
	end
endmodule // uprd_client_sink

// ### verification/uprd_dispatch_bench.sv
// bench for the dispatcher: drives datagrams, models resources
// assumes the client model logs replies
module uprd_dispatch_bench;
	timeunit 1ns;
	timeprecision 1ps;
	reg         clock_in, rst_b_in, ip_load_in, rx_valid_in, rx_last_in;
	reg         stall;
	reg  [31:0] ip_value_in, rx_dst_ip_in, rx_src_ip_in;
	reg  [15:0] rx_src_port_in, rx_dst_port_in, rx_udp_len_in;
	reg  [7:0]  rx_data_in;
	reg  [4:0]  rsp_en, pend;
	wire [4:0]  cmd_valid_out, cmd_last_out, rsp_ready_out, busy_out;
	wire [4:0]  rsp_valid_in;
	wire [7:0]  tx_data_out;
	wire [15:0] tx_dst_port_out, tx_src_port_out, tx_udp_len_out;
	wire [31:0] tx_dst_ip_out, ip_addr_out;
	wire        rx_ready_out, tx_valid_out, tx_ready_in, tx_last_out;
	wire        drop_out, self_reset_out;
	int         n_errors, checked;
	uprd_dispatch #(.TIMEOUT_CYC(32'd2000)) uut (.*, .cmd_ready_in(5'h1f),
		.cmd_data_out(), .rsp_data_in(40'ha4a3a2a1a0), .rsp_last_in(5'h1f),
		.rsp_len_in({5{11'h001}}));
	uprd_client_sink client (
		.clock_in(clock_in), .stall_in(stall), .tx_valid_in(tx_valid_out),
		.tx_data_in(tx_data_out), .tx_last_in(tx_last_out),
		.tx_dst_ip_in(tx_dst_ip_out), .tx_dst_port_in(tx_dst_port_out),
		.tx_src_port_in(tx_src_port_out), .tx_udp_len_in(tx_udp_len_out),
		.tx_ready_out(tx_ready_in));
	// ------------------------------------------------------------
	// resources: one reply byte per command, held back by rsp_en
	// ------------------------------------------------------------
	always @(posedge clock_in) begin
		if (!rst_b_in || self_reset_out)
			pend <= 5'h00;
		else
			pend <= (pend | (cmd_valid_out & cmd_last_out))
				& ~(rsp_valid_in & rsp_ready_out);
	end
	assign rsp_valid_in = pend & rsp_en;
	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task chk(input string what, input [31:0] exp, input [31:0] got);
		checked = checked + 1;
		if (got !== exp) begin
			$display("BAD %s exp %h got %h", what, exp, got);
			n_errors = n_errors + 1;
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// one datagram, one byte a beat, header held throughout
	task send(input [15:0] port, input [31:0] ip, input [15:0] sp,
		input [15:0] ulen, input int nb);
		@(negedge clock_in);
		rx_dst_port_in = port;
		rx_dst_ip_in = ip;
		rx_src_port_in = sp;
		rx_udp_len_in = ulen;
		for (int i = 0; i < nb; i++) begin
			rx_valid_in = 1'b1;
			rx_data_in = i[7:0];
			rx_last_in = (i == nb - 1);
			@(negedge clock_in);
		end
		rx_valid_in = 1'b0;
		rx_last_in = 1'b0;
	endtask
	task wait_rsp(input int n);
		int k;
		k = 0;
		while (client.n_rsp < n && k < 400) begin
			@(negedge clock_in);
			k++;
		end
		if (client.n_rsp < n) begin
			n_errors++;
			stop_test;
		end
	endtask
	task wait_drop;
		int k;
		k = 0;
		while (drop_out !== 1'b1 && k < 8) begin
			@(negedge clock_in);
			k++;
		end
		chk("drop", 1, drop_out);
	endtask
	task set_ip(input [31:0] v);
		ip_load_in = 1'b1;
		ip_value_in = v;
		@(negedge clock_in);
		ip_load_in = 1'b0;
		chk("own ip", v, ip_addr_out);
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_route;
		int b;
		b = client.n_rsp;
		for (int r = 0; r < 5; r++) begin
			rx_src_ip_in = 32'hc0a80010 + r;
			send(16'h2710 + r, 32'h0a0a0a01, 16'h4000 + r, 16'h000b, 3);
			wait_rsp(b + r + 1);
			chk("src port", 16'h2710 + r, client.sport[b + r]);
			chk("dst port", 16'h4000 + r, client.dport[b + r]);
			chk("dst ip", 32'hc0a80010 + r, client.dip[b + r]);
			chk("reply", 8'ha0 + r, client.dat[b + r]);
		end
		chk("reply size", 0, client.bad_len);
		$display("t_route done");
	endtask
	task t_drop;
		int b;
		b = client.n_rsp;
		send(16'h2715, 32'h0a0a0a01, 16'h5000, 16'h000b, 3);
		wait_drop;
		send(16'h270f, 32'h0a0a0a01, 16'h5000, 16'h000b, 3);
		wait_drop;
		send(16'h2711, 32'h0a0a0a01, 16'h5000, 16'h000b, 2);
		wait_drop;
		send(16'h2711, 32'h0a0a0a01, 16'h5000, 16'h0008, 1);
		wait_drop;
		set_ip(32'h0a0a0a07);
		send(16'h2710, 32'h0a0a0a01, 16'h5000, 16'h000b, 3);
		wait_drop;
		send(16'h2710, 32'h0a0a0a07, 16'h5001, 16'h000b, 3);
		wait_rsp(b + 1);
		chk("new ip reply", 16'h5001, client.dport[b]);
		set_ip(32'h0a0a0a01);
		$display("t_drop done");
	endtask
	task t_queue;
		int b;
		b = client.n_rsp;
		rsp_en = 5'h1d;
		send(16'h2711, 32'h0a0a0a01, 16'h0101, 16'h000b, 3);
		send(16'h2711, 32'h0a0a0a01, 16'h0202, 16'h000b, 3);
		send(16'h2712, 32'h0a0a0a01, 16'h0303, 16'h000b, 3);
		wait_rsp(b + 1);
		repeat (2) @(negedge clock_in);
		chk("other first", 16'h0303, client.dport[b]);
		chk("busy", 5'h02, busy_out);
		stall = 1'b1;
		rsp_en = 5'h1f;
		repeat (30) @(negedge clock_in);
		chk("stalled", b + 1, client.n_rsp);
		chk("held", 1, tx_valid_out);
		stall = 1'b0;
		wait_rsp(b + 3);
		chk("first", 16'h0101, client.dport[b + 1]);
		chk("second", 16'h0202, client.dport[b + 2]);
		$display("t_queue done");
	endtask
	task t_wdog;
		int k;
		k = 0;
		rsp_en = 5'h1d;
		send(16'h2711, 32'h0a0a0a01, 16'h0404, 16'h000b, 3);
		repeat (8) @(negedge clock_in);
		chk("busy", 5'h02, busy_out);
		while (self_reset_out !== 1'b1 && k < 2100) begin
			@(negedge clock_in);
			k++;
		end
		chk("self reset", 1, self_reset_out);
		repeat (2) @(negedge clock_in);
		chk("cleared", 0, busy_out);
		$display("t_wdog done");
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{rst_b_in, ip_load_in, rx_valid_in, rx_last_in, stall} = 5'h00;
		rsp_en = 5'h1f;
		n_errors = 0;
		checked = 0;
		repeat (2) @(negedge clock_in);
		rst_b_in = 1'b1;
		repeat (2) @(negedge clock_in);
		chk("reset ip", 32'h0a0a0a01, ip_addr_out);
		chk("reset busy", 0, busy_out);
		$display("t_reset done");
		t_route;
		t_drop;
		t_queue;
		t_wdog;
		stop_test;
	end
endmodule // uprd_dispatch_bench
